// ==== design/mptl_fault_mem.sv ====
// Small fault history memory with registered read data
`timescale 1ns/1ns
`default_nettype none

module mptl_fault_mem #(
	parameter int unsigned WIDTH = 36,
	parameter int unsigned DEPTH = 5,
	parameter int unsigned AW = 3
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rd;
	} mptl_mem_st_t;

	mptl_mem_st_t s;
	mptl_mem_st_t next_s;

	// Write one entry; an address beyond the depth reads as zero
	always_comb begin
		next_s = s;
		if (wrEn && (32'(wrAddr) < DEPTH)) begin
			next_s.mem[wrAddr] = wrData;
		end
		next_s.rd = (32'(rdAddr) < DEPTH) ? s.mem[rdAddr] : '0;
	end

	// State register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rdData = s.rd;

endmodule
`default_nettype wire

// ==== design/mptl_map.svh ====
// Constants of the motor protection trip logic: timing, thresholds, reset values, setting selects
`ifndef MPTL_MAP_SVH
`define MPTL_MAP_SVH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define MPTL_CLK_HZ 32'h0098_9680
`define MPTL_MS_PER_SEC 32'h0000_03E8
`define MPTL_MS_CYC (`MPTL_CLK_HZ / `MPTL_MS_PER_SEC)

// ----------------------------------------
// Protection figures (seconds, milliseconds, percent of rated)
// ----------------------------------------
`define MPTL_PF_SEC 8'h03
`define MPTL_UNB_SEC 8'h05
`define MPTL_UC_SEC 8'h03
`define MPTL_START_SEC 8'h0A
`define MPTL_INST_MS 13'h0014
`define MPTL_ZERO_PCT 12'h001E
`define MPTL_OC_PCT 12'h0064
`define MPTL_STALL_PCT 12'h012C
`define MPTL_CLASS_W 26'h005_7E40
`define MPTL_SEC_PER_MIN 11'h03C
`define MPTL_SEC_PER_HR 12'hE10
`define MPTL_HIST_DEPTH 5

// ----------------------------------------
// Setting reset values
// ----------------------------------------
`define MPTL_RST_CLASS 6'h0A
`define MPTL_RST_DDELAY 8'h05
`define MPTL_RST_OTIME 8'h05
`define MPTL_RST_UNB 7'h32
`define MPTL_RST_INH 8'h05
`define MPTL_RST_REV_MS 10'h064
`define MPTL_RST_UC 7'h1E
`define MPTL_RST_GND_MA 12'h01E
`define MPTL_RST_GND_MS 13'h0064
`define MPTL_RST_INST 12'h01F4
`define MPTL_RST_AUTO_MIN 5'h01

// ----------------------------------------
// Setting selects
// ----------------------------------------
`define MPTL_SEL_CLASS 4'h0
`define MPTL_SEL_DTMODE 4'h1
`define MPTL_SEL_DDELAY 4'h2
`define MPTL_SEL_OTIME 4'h3
`define MPTL_SEL_UNB 4'h4
`define MPTL_SEL_PFINH 4'h5
`define MPTL_SEL_GNDINH 4'h6
`define MPTL_SEL_INSTINH 4'h7
`define MPTL_SEL_REVMS 4'h8
`define MPTL_SEL_UC 4'h9
`define MPTL_SEL_GNDMA 4'hA
`define MPTL_SEL_GNDMS 4'hB
`define MPTL_SEL_INST 4'hC
`define MPTL_SEL_AUTOMIN 4'hD
`define MPTL_SEL_FLAGS 4'hE
`define MPTL_SEL_HOURS 4'hF

`endif

// ==== design/mptl_pkg.sv ====
// Types of the motor protection trip logic
`default_nettype none
package mptl_pkg;

	// ----------------------------------------
	// Trip causes
	// ----------------------------------------
	typedef enum logic [3:0] {
		CAUSE_NONE, CAUSE_OVERCUR, CAUSE_STALL, CAUSE_PHFAIL, CAUSE_UNBAL,
		CAUSE_REVERSE, CAUSE_UNDER, CAUSE_GROUND, CAUSE_INST
	} mptl_cause_t;

	// ----------------------------------------
	// Operator settings
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] cls;
		logic dtMode;
		logic [7:0] dDelay;
		logic [7:0] oTime;
		logic [6:0] unbThr;
		logic [7:0] pfInh;
		logic [7:0] gndInh;
		logic [7:0] instInh;
		logic [9:0] revMs;
		logic [6:0] ucPct;
		logic [11:0] gndMa;
		logic [12:0] gndMs;
		logic [11:0] instPct;
		logic [4:0] autoMin;
		logic ucEn;
		logic autoEn;
		logic singlePh;
		logic auxRoute;
		logic [15:0] hourLimit;
	} mptl_set_t;

	// ----------------------------------------
	// Whole state of the trip logic
	// ----------------------------------------
	typedef struct packed {
		mptl_set_t set;
		logic unlocked;
		logic rejected;
		logic [7:0] runSec;
		logic [25:0] thermal;
		logic [7:0] dtCnt;
		logic [7:0] stallCnt;
		logic [7:0] pfCnt;
		logic [7:0] unbCnt;
		logic [7:0] ucCnt;
		logic [9:0] revCnt;
		logic [12:0] gndCnt;
		logic [12:0] instCnt;
		logic tripped;
		logic aux;
		mptl_cause_t cause;
		logic [10:0] autoCnt;
		logic [11:0] hrSec;
		logic [15:0] hours;
		logic maint;
		logic [1:0] dispPh;
		logic dispSec;
		logic [11:0] dispCur;
		logic [2:0] wrPtr;
		logic [2:0] histCount;
	} mptl_state_t;

endpackage
`default_nettype wire

// ==== design/mptl_tick_gen.sv ====
// Millisecond and second tick enables for the protection timers
`timescale 1ns/1ns
`default_nettype none
`include "mptl_map.svh"

module mptl_tick_gen #(
	parameter int unsigned MS_CYC = `MPTL_MS_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	output logic msTick,
	output logic secTick
);

	typedef struct packed {
		logic [15:0] cyc;
		logic [9:0] ms;
		logic msTick;
		logic secTick;
	} mptl_tick_st_t;

	mptl_tick_st_t s;
	mptl_tick_st_t next_s;

	// Divider chain: clock cycles to ms, ms to seconds
	always_comb begin
		next_s = s;
		next_s.msTick = 1'b0;
		next_s.secTick = 1'b0;
		if (s.cyc == 16'(MS_CYC - 1)) begin
			next_s.cyc = 16'h0000;
			next_s.msTick = 1'b1;
			if (s.ms == 10'(`MPTL_MS_PER_SEC - 1)) begin
				next_s.ms = 10'h000;
				next_s.secTick = 1'b1;
			end else begin
				next_s.ms = s.ms + 10'h001;
			end
		end else begin
			next_s.cyc = s.cyc + 16'h0001;
		end
	end

	// State register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign msTick = s.msTick;
	assign secTick = s.secTick;

endmodule
`default_nettype wire

// ==== design/mptl_trip_logic.sv ====
// Motor protection trip logic: protection timers, trip latch, history, settings, hours, display
`timescale 1ns/1ns
`default_nettype none
`include "mptl_map.svh"

module mptl_trip_logic #(
	parameter int unsigned MS_CYC = `MPTL_MS_CYC,
	parameter logic [15:0] PASSWORD = 16'h1234
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [11:0] phA,
	input wire logic [11:0] phB,
	input wire logic [11:0] phC,
	input wire logic [11:0] leakMa,
	input wire logic seqReverse,
	input wire logic [31:0] dateTime,
	input wire logic manualReset,
	input wire logic elecReset,
	input wire logic pwdStrobe,
	input wire logic [15:0] pwdIn,
	input wire logic lockReq,
	input wire logic setWe,
	input wire logic [3:0] setSel,
	input wire logic [15:0] setData,
	input wire logic [2:0] histIdx,
	output logic tripOut,
	output logic auxTrip,
	output logic [3:0] tripCause,
	output logic setReject,
	output logic unlocked,
	output logic maintAlarm,
	output logic [15:0] hoursRun,
	output logic [1:0] dispPhase,
	output logic [11:0] dispCurrent,
	output logic [35:0] histData,
	output logic [2:0] histCount
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Small readings are noise from the sensor, not motor current
	function automatic logic [11:0] mptlZeroCut(input logic [11:0] x);
		return (x < `MPTL_ZERO_PCT) ? 12'h000 : x;
	endfunction

	// Saturating increment of a timer gated by a tick
	function automatic logic [12:0] mptlStep(input logic [12:0] c, input logic tick);
		return (tick && c != 13'h1FFF) ? c + 13'h0001 : c;
	endfunction

	// ----------------------------------------
	// State and tick sources
	// ----------------------------------------
	mptl_pkg::mptl_state_t s;
	mptl_pkg::mptl_state_t next_s;
	logic msTick;
	logic secTick;
	logic [11:0] cA;
	logic [11:0] cB;
	logic [11:0] cC;
	logic [11:0] mx;
	logic [11:0] mn;
	logic run;
	logic startup;
	logic [18:0] unbDiff;
	logic [18:0] unbRef;
	logic unbFull;
	logic unbOver;
	logic [25:0] thermLim;
	logic [10:0] autoLim;
	logic [3:0] rdSum;
	logic [2:0] rdAddr;
	logic memWe;
	mptl_pkg::mptl_cause_t hit;

	mptl_tick_gen #(
		.MS_CYC(MS_CYC)
	) u_tick (
		.mclk(mclk),
		.rst_b(rst_b),
		.msTick(msTick),
		.secTick(secTick)
	);

	// ----------------------------------------
	// Measurement conditioning
	// ----------------------------------------

	// Phase maxima and minima; single phase mode looks at all three but skips balance checks
	always_comb begin
		cA = mptlZeroCut(phA);
		cB = mptlZeroCut(phB);
		cC = mptlZeroCut(phC);
		mx = cA;
		mn = cA;
		if (cB > mx) mx = cB;
		if (cC > mx) mx = cC;
		if (cB < mn) mn = cB;
		if (cC < mn) mn = cC;
		run = (mx != 12'h000);
		startup = run && (s.runSec < `MPTL_START_SEC);
		// Compare without a divider: (max-min)*100 against threshold*max
		unbDiff = 19'(mx - mn) * 19'h0064;
		unbRef = 19'(s.set.unbThr) * 19'(mx);
		unbFull = run && (mn == 12'h000) && !s.set.singlePh;
		unbOver = run && (unbDiff >= unbRef) && !s.set.singlePh;
		thermLim = 26'(s.set.cls) * `MPTL_CLASS_W;
		autoLim = 11'(s.set.autoMin) * `MPTL_SEC_PER_MIN;
	end

	// ----------------------------------------
	// Fault detection, highest priority first
	// ----------------------------------------
	always_comb begin
		hit = mptl_pkg::CAUSE_NONE;
		if (s.instCnt >= `MPTL_INST_MS) begin
			hit = mptl_pkg::CAUSE_INST;
		end else if (s.gndCnt >= s.set.gndMs) begin
			hit = mptl_pkg::CAUSE_GROUND;
		end else if (s.pfCnt >= `MPTL_PF_SEC) begin
			hit = mptl_pkg::CAUSE_PHFAIL;
		end else if (s.revCnt >= s.set.revMs) begin
			hit = mptl_pkg::CAUSE_REVERSE;
		end else if (s.unbCnt >= `MPTL_UNB_SEC) begin
			hit = mptl_pkg::CAUSE_UNBAL;
		end else if (s.stallCnt >= s.set.oTime && s.set.oTime != 8'h00) begin
			hit = mptl_pkg::CAUSE_STALL;
		end else if (s.set.dtMode ? (s.dtCnt > s.set.oTime) : (s.thermal >= thermLim && thermLim != 26'h000_0000)) begin
			hit = mptl_pkg::CAUSE_OVERCUR;
		end else if (s.ucCnt >= `MPTL_UC_SEC) begin
			hit = mptl_pkg::CAUSE_UNDER;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.rejected = 1'b0;
		memWe = 1'b0;

		// Password gate: a wrong entry locks again
		if (lockReq) begin
			next_s.unlocked = 1'b0;
		end else if (pwdStrobe) begin
			next_s.unlocked = (pwdIn == PASSWORD);
		end

		// Setting writes; refused writes pulse the reject flag
		if (setWe && !s.unlocked) begin
			next_s.rejected = 1'b1;
		end else if (setWe) begin
			unique case (setSel)
				`MPTL_SEL_CLASS: next_s.set.cls = (setData[5:0] == 6'h00) ? 6'h01 : ((setData[5:0] > 6'h3C) ? 6'h3C : setData[5:0]);
				`MPTL_SEL_DTMODE: next_s.set.dtMode = setData[0];
				`MPTL_SEL_DDELAY: next_s.set.dDelay = setData[7:0];
				`MPTL_SEL_OTIME: next_s.set.oTime = setData[7:0];
				`MPTL_SEL_UNB: next_s.set.unbThr = setData[6:0];
				`MPTL_SEL_PFINH: next_s.set.pfInh = setData[7:0];
				`MPTL_SEL_GNDINH: next_s.set.gndInh = setData[7:0];
				`MPTL_SEL_INSTINH: next_s.set.instInh = setData[7:0];
				`MPTL_SEL_REVMS: next_s.set.revMs = setData[9:0];
				`MPTL_SEL_UC: next_s.set.ucPct = setData[6:0];
				`MPTL_SEL_GNDMA: next_s.set.gndMa = setData[11:0];
				`MPTL_SEL_GNDMS: next_s.set.gndMs = setData[12:0];
				`MPTL_SEL_INST: next_s.set.instPct = setData[11:0];
				`MPTL_SEL_AUTOMIN: next_s.set.autoMin = setData[4:0];
				`MPTL_SEL_FLAGS: begin
					next_s.set.ucEn = setData[0];
					next_s.set.autoEn = setData[1];
					next_s.set.singlePh = setData[2];
					next_s.set.auxRoute = setData[3];
				end
				`MPTL_SEL_HOURS: next_s.set.hourLimit = setData;
			endcase
		end

		// Seconds since start; zero while the motor stands
		if (!run) begin
			next_s.runSec = 8'h00;
		end else if (secTick && s.runSec != 8'hFF) begin
			next_s.runSec = s.runSec + 8'h01;
		end

		// Inverse time heat sum; non-thermal, so it drops when current falls back
		if (s.set.dtMode || mx <= `MPTL_OC_PCT) begin
			next_s.thermal = 26'h000_0000;
		end else if (secTick && s.thermal < thermLim) begin
			next_s.thermal = s.thermal + 26'(mx) * 26'(mx);
		end

		// Definite time: counting starts only after the operation delay
		if (s.set.dtMode && run && s.runSec >= s.set.dDelay && mx > `MPTL_OC_PCT) begin
			next_s.dtCnt = 8'(mptlStep(13'(s.dtCnt), secTick));
		end else begin
			next_s.dtCnt = 8'h00;
		end

		// Locked rotor or start that never settles
		next_s.stallCnt = (run && !startup && mx >= `MPTL_STALL_PCT) ? 8'(mptlStep(13'(s.stallCnt), secTick)) : 8'h00;

		// Phase fail and unbalance share the phase fail inhibit
		next_s.pfCnt = (unbFull && s.runSec >= s.set.pfInh) ? 8'(mptlStep(13'(s.pfCnt), secTick)) : 8'h00;
		next_s.unbCnt = (unbOver && s.runSec >= s.set.pfInh) ? 8'(mptlStep(13'(s.unbCnt), secTick)) : 8'h00;

		// Reverse sequence only while starting
		next_s.revCnt = (startup && !s.set.singlePh && seqReverse) ? 10'(mptlStep(13'(s.revCnt), msTick)) : 10'h000;

		// Undercurrent only while the motor runs
		next_s.ucCnt = (s.set.ucEn && run && mx < 12'(s.set.ucPct)) ? 8'(mptlStep(13'(s.ucCnt), secTick)) : 8'h00;

		// Ground leakage and short circuit on the millisecond tick
		next_s.gndCnt = (s.runSec >= s.set.gndInh && leakMa > s.set.gndMa) ? mptlStep(s.gndCnt, msTick) : 13'h0000;
		next_s.instCnt = (run && s.runSec >= s.set.instInh && mx >= s.set.instPct) ? mptlStep(s.instCnt, msTick) : 13'h0000;

		// Trip latch keeps the first cause
		if (!s.tripped && hit != mptl_pkg::CAUSE_NONE) begin
			next_s.tripped = 1'b1;
			next_s.cause = hit;
			next_s.aux = s.set.auxRoute && (hit == mptl_pkg::CAUSE_INST || hit == mptl_pkg::CAUSE_GROUND);
			next_s.autoCnt = 11'h000;
			memWe = 1'b1;
			next_s.wrPtr = (s.wrPtr == 3'(`MPTL_HIST_DEPTH - 1)) ? 3'h0 : s.wrPtr + 3'h1;
			if (s.histCount != 3'(`MPTL_HIST_DEPTH)) next_s.histCount = s.histCount + 3'h1;
		end

		// Automatic reset counts only for overcurrent trips
		if (s.tripped && s.set.autoEn && s.cause == mptl_pkg::CAUSE_OVERCUR && secTick) begin
			next_s.autoCnt = s.autoCnt + 11'h001;
		end

		// Clearing the latch; heat sum cleared too or it would trip again at once
		if (s.tripped && (manualReset || elecReset || (s.set.autoEn && s.cause == mptl_pkg::CAUSE_OVERCUR
				&& s.set.autoMin != 5'h00 && s.autoCnt >= autoLim))) begin
			next_s.tripped = 1'b0;
			next_s.aux = 1'b0;
			next_s.cause = mptl_pkg::CAUSE_NONE;
			next_s.thermal = 26'h000_0000;
			next_s.autoCnt = 11'h000;
		end

		// Running hours; hour counter saturates rather than wraps
		if (run && secTick) begin
			if (s.hrSec == `MPTL_SEC_PER_HR - 12'h001) begin
				next_s.hrSec = 12'h000;
				if (s.hours != 16'hFFFF) next_s.hours = s.hours + 16'h0001;
			end else begin
				next_s.hrSec = s.hrSec + 12'h001;
			end
		end
		next_s.maint = (s.set.hourLimit != 16'h0000) && (s.hours >= s.set.hourLimit);

		// Display rotation, two seconds per phase
		if (secTick) begin
			next_s.dispSec = !s.dispSec;
			if (s.dispSec) next_s.dispPh = (s.dispPh == 2'h2) ? 2'h0 : s.dispPh + 2'h1;
		end
		unique case (s.dispPh)
			2'h0: next_s.dispCur = cA;
			2'h1: next_s.dispCur = cB;
			2'h2: next_s.dispCur = cC;
			default: next_s.dispCur = 12'h000;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
			s.set.cls <= `MPTL_RST_CLASS;
			s.set.dDelay <= `MPTL_RST_DDELAY;
			s.set.oTime <= `MPTL_RST_OTIME;
			s.set.unbThr <= `MPTL_RST_UNB;
			s.set.pfInh <= `MPTL_RST_INH;
			s.set.gndInh <= `MPTL_RST_INH;
			s.set.instInh <= `MPTL_RST_INH;
			s.set.revMs <= `MPTL_RST_REV_MS;
			s.set.ucPct <= `MPTL_RST_UC;
			s.set.gndMa <= `MPTL_RST_GND_MA;
			s.set.gndMs <= `MPTL_RST_GND_MS;
			s.set.instPct <= `MPTL_RST_INST;
			s.set.autoMin <= `MPTL_RST_AUTO_MIN;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Fault history, newest entry at index zero
	// ----------------------------------------
	always_comb begin
		rdSum = 4'(s.wrPtr) + 4'(`MPTL_HIST_DEPTH - 1) - 4'(histIdx);
		rdAddr = (rdSum >= 4'(`MPTL_HIST_DEPTH)) ? 3'(rdSum - 4'(`MPTL_HIST_DEPTH)) : rdSum[2:0];
		if (histIdx >= 3'(`MPTL_HIST_DEPTH)) rdAddr = 3'h7;
	end

	mptl_fault_mem #(
		.WIDTH(36),
		.DEPTH(`MPTL_HIST_DEPTH),
		.AW(3)
	) u_hist (
		.mclk(mclk),
		.rst_b(rst_b),
		.wrEn(memWe),
		.wrAddr(s.wrPtr),
		.wrData({hit, dateTime}),
		.rdAddr(rdAddr),
		.rdData(histData)
	);

	// ----------------------------------------
	// Outputs, all from the state register
	// ----------------------------------------
	assign tripOut = s.tripped && !s.aux;
	assign auxTrip = s.tripped && s.aux;
	assign tripCause = s.cause;
	assign setReject = s.rejected;
	assign unlocked = s.unlocked;
	assign maintAlarm = s.maint;
	assign hoursRun = s.hours;
	assign dispPhase = s.dispPh;
	assign dispCurrent = s.dispCur;
	assign histCount = s.histCount;

endmodule
`default_nettype wire

// ==== test/mptl_motor_model.sv ====
// Motor, current sensors and trip contactor facing the trip logic
`timescale 1ns/1ns
`default_nettype none

module mptl_motor_model (
	input wire logic mclk,
	input wire logic [11:0] loadPct,
	input wire logic [1:0] dropPh,
	input wire logic [11:0] leakCmd,
	input wire logic revCmd,
	input wire logic tripOut,
	input wire logic auxTrip,
	output logic [11:0] phA,
	output logic [11:0] phB,
	output logic [11:0] phC,
	output logic [11:0] leakMa,
	output logic seqReverse
);
	logic open = 1'b0;

	// Contactor drops out one cycle after either trip contact closes
	always_ff @(posedge mclk) begin
		open <= tripOut | auxTrip;
	end

	// Opened contactor kills all currents, so a held trip never sees a live fault
	assign phA = (open || dropPh == 2'h1) ? 12'h000 : loadPct;
	assign phB = (open || dropPh == 2'h2) ? 12'h000 : loadPct;
	assign phC = (open || dropPh == 2'h3) ? 12'h000 : loadPct;
	assign leakMa = open ? 12'h000 : leakCmd;
	assign seqReverse = revCmd;
endmodule
`default_nettype wire

// ==== test/mptl_trip_sva.sv ====
// Port checker of the motor protection trip logic
`timescale 1ns/1ns
`default_nettype none

module mptl_trip_sva #(
	parameter int unsigned MS_CYC = 10,
	parameter logic [15:0] PASSWORD = 16'h1234
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic manualReset,
	input wire logic elecReset,
	input wire logic pwdStrobe,
	input wire logic [15:0] pwdIn,
	input wire logic lockReq,
	input wire logic setWe,
	input wire logic tripOut,
	input wire logic auxTrip,
	input wire logic [3:0] tripCause,
	input wire logic setReject,
	input wire logic unlocked,
	input wire logic [1:0] dispPhase,
	input wire logic [2:0] histCount
);
	typedef struct packed {
		logic [31:0] age;
		logic seen;
		logic [1:0] lastPh;
	} mptl_sva_state_t;
	mptl_sva_state_t st;
	mptl_sva_state_t next_st;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Display step age
	// ----------------------------------------
	// First step after reset is skipped: tick phase is unknown then
	always_comb begin
		next_st = st;
		next_st.age = st.age + 32'h0000_0001;
		next_st.lastPh = dispPhase;
		if (dispPhase != st.lastPh) begin
			next_st.age = 32'h0000_0000;
			next_st.seen = 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Settings lock
	// ----------------------------------------
	sequence s_clear;
		(manualReset || elecReset) && (tripOut || auxTrip);
	endsequence
	sequence s_held;
		(tripOut || auxTrip) && tripCause != 4'h1 && !manualReset && !elecReset;
	endsequence
	a_locked_write: assert property (setWe && !unlocked |=> setReject) else $error("locked write not refused");
	a_reject_cause: assert property (setReject |-> $past(rst_b) && $past(setWe) && !$past(unlocked))
		else $error("refusal without locked write");
	a_pwd_good: assert property (pwdStrobe && !lockReq && pwdIn == PASSWORD |=> unlocked)
		else $error("good password not accepted");
	a_pwd_lock: assert property (lockReq || (pwdStrobe && pwdIn != PASSWORD) |=> !unlocked)
		else $error("settings not locked");

	// ----------------------------------------
	// Trip latch and history
	// ----------------------------------------
	a_trip_clear: assert property (s_clear |=> !tripOut && !auxTrip) else $error("trip not cleared");
	a_trip_latch: assert property (s_held |=> (tripOut || auxTrip) && $stable(tripCause))
		else $error("trip or cause dropped");
	a_cause_set: assert property (tripOut || auxTrip |-> tripCause inside {[4'h1:4'h8]})
		else $error("trip without cause");
	a_hist_step: assert property ($past(rst_b) && !$stable(histCount) |-> histCount == $past(histCount) + 3'h1
		&& histCount <= 3'h5) else $error("history count step");

	// ----------------------------------------
	// Phase display rotation
	// ----------------------------------------
	a_disp_order: assert property ($past(rst_b) && !$stable(dispPhase) |->
		dispPhase == (($past(dispPhase) == 2'h2) ? 2'h0 : $past(dispPhase) + 2'h1))
		else $error("display phase order");
	a_disp_period: assert property (!$stable(dispPhase) && st.seen |-> st.age >= 1990 * MS_CYC)
		else $error("display step too early");
	a_disp_alive: assert property (st.age < 2010 * MS_CYC) else $error("display step too late");
endmodule

bind mptl_trip_logic mptl_trip_sva #(.MS_CYC(MS_CYC), .PASSWORD(PASSWORD)) u_sva (.mclk(mclk), .rst_b(rst_b),
	.manualReset(manualReset), .elecReset(elecReset), .pwdStrobe(pwdStrobe), .pwdIn(pwdIn),
	.lockReq(lockReq), .setWe(setWe), .tripOut(tripOut), .auxTrip(auxTrip), .tripCause(tripCause),
	.setReject(setReject), .unlocked(unlocked), .dispPhase(dispPhase), .histCount(histCount));
`default_nettype wire

// ==== test/test_mptl_trip_logic.sv ====
// Self-checking bench of the motor protection trip logic
`timescale 1ns/1ns
`default_nettype none
`include "mptl_map.svh"

module test_mptl_trip_logic;
	localparam int unsigned MSC = 2;
	localparam int SEC = 2000;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [11:0] phA, phB, phC, leakMa, loadPct, leakCmd, dispCurrent;
	logic [1:0] dropPh, dispPhase;
	logic revCmd, seqReverse, manualReset, elecReset, pwdStrobe, lockReq, setWe;
	logic tripOut, auxTrip, setReject, unlocked, maintAlarm;
	logic rejSeen;
	logic [31:0] dateTime;
	logic [15:0] pwdIn, setData, hoursRun;
	logic [3:0] setSel, tripCause;
	logic [2:0] histIdx, histCount;
	logic [35:0] histData;
	logic [3:0] expCause [5] = '{4'h6, 4'h7, 4'h3, 4'h5, 4'h8};
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;

	mptl_trip_logic #(.MS_CYC(MSC), .PASSWORD(16'h1234)) dut (.mclk(mclk), .rst_b(rst_b), .phA(phA), .phB(phB),
		.phC(phC), .leakMa(leakMa), .seqReverse(seqReverse), .dateTime(dateTime), .manualReset(manualReset),
		.elecReset(elecReset), .pwdStrobe(pwdStrobe), .pwdIn(pwdIn), .lockReq(lockReq), .setWe(setWe),
		.setSel(setSel), .setData(setData), .histIdx(histIdx), .tripOut(tripOut), .auxTrip(auxTrip),
		.tripCause(tripCause), .setReject(setReject), .unlocked(unlocked), .maintAlarm(maintAlarm),
		.hoursRun(hoursRun), .dispPhase(dispPhase), .dispCurrent(dispCurrent), .histData(histData),
		.histCount(histCount));
	mptl_motor_model u_motor (.mclk(mclk), .loadPct(loadPct), .dropPh(dropPh), .leakCmd(leakCmd),
		.revCmd(revCmd), .tripOut(tripOut), .auxTrip(auxTrip), .phA(phA), .phB(phB), .phC(phC),
		.leakMa(leakMa), .seqReverse(seqReverse));

	// ----------------------------------------
	// Clock, timeout and verdict
	// ----------------------------------------
	always #50 mclk = ~mclk;
	// Ceiling well above the 40000 cycles the sequence needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			finish_test();
		end
	end
	task finish_test;
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task cyc(input int k);
		repeat (k) begin
			@(posedge mclk);
			#10;
		end
	endtask
	task chk(input logic [35:0] got, input logic [35:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// Reject pulse stands one cycle, so it is caught before the idle edge that spaces two writes
	task wr(input logic [3:0] sel, input logic [15:0] val);
		setWe = 1'b1;
		setSel = sel;
		setData = val;
		cyc(1);
		rejSeen = setReject;
		setWe = 1'b0;
		cyc(1);
	endtask
	task pwd(input logic [15:0] val);
		pwdStrobe = 1'b1;
		pwdIn = val;
		cyc(1);
		pwdStrobe = 1'b0;
		cyc(1);
	endtask
	// Counts cycles until a trip shows, bounded by lim
	task wait_trip(input int lim, output int k);
		k = 0;
		while (tripOut !== 1'b1 && auxTrip !== 1'b1 && k < lim) begin
			cyc(1);
			k++;
		end
	endtask
	// Stops the motor, checks the latch holds, then resets it
	task clr(input logic elec);
		loadPct = 12'h000;
		leakCmd = 12'h000;
		revCmd = 1'b0;
		dropPh = 2'h0;
		cyc(20);
		chk(tripOut | auxTrip, 1'b1, "trip held");
		manualReset = !elec;
		elecReset = elec;
		cyc(1);
		manualReset = 1'b0;
		elecReset = 1'b0;
		cyc(1);
		chk({tripOut, auxTrip}, 2'h0, "trip cleared");
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{loadPct, leakCmd, dropPh, revCmd, dateTime, histIdx} = '0;
		{manualReset, elecReset, pwdStrobe, pwdIn, lockReq, setWe, setSel, setData} = '0;
		cyc(12);
		rst_b = 1'b1;
		cyc(1);
		chk({tripOut, auxTrip, unlocked, histCount}, 6'h00, "reset outputs");
		wr(`MPTL_SEL_INSTINH, 16'h0000);
		chk(rejSeen, 1'b1, "locked write");
		pwd(16'h4321);
		chk(unlocked, 1'b0, "bad password");
		pwd(16'h1234);
		chk(unlocked, 1'b1, "good password");
		wr(`MPTL_SEL_INSTINH, 16'h0000);
		chk(rejSeen, 1'b0, "open write");
		wr(`MPTL_SEL_PFINH, 16'h0000);
		wr(`MPTL_SEL_GNDINH, 16'h0000);
		wr(`MPTL_SEL_REVMS, 16'h00C8);
		wr(`MPTL_SEL_UC, 16'h003C);
		dateTime = 32'h0000_0001;
		loadPct = 12'h258;
		wait_trip(200, n);
		chk(n >= 36 && n <= 102, 1'b1, "inst delay");
		chk({tripOut, tripCause}, {1'b1, 4'h8}, "inst cause");
		clr(1'b0);
		dateTime = 32'h0000_0002;
		loadPct = 12'h064;
		revCmd = 1'b1;
		wait_trip(600, n);
		chk(n >= 390 && n <= 410, 1'b1, "reverse delay");
		chk(tripCause, 4'h5, "reverse cause");
		clr(1'b1);
		loadPct = 12'h064;
		cyc(SEC * 21 / 2);
		chk(dispCurrent, 12'h064, "display current");
		revCmd = 1'b1;
		wait_trip(800, n);
		chk(n, 800, "reverse while running");
		loadPct = 12'h000;
		revCmd = 1'b0;
		cyc(5);
		dateTime = 32'h0000_0003;
		loadPct = 12'h064;
		dropPh = 2'h3;
		wait_trip(7000, n);
		chk(n > 2 * SEC - 5 && n <= 3 * SEC + 10, 1'b1, "phase fail delay");
		chk(tripCause, 4'h3, "phase fail cause");
		clr(1'b0);
		loadPct = 12'h014;
		cyc(10);
		chk(dispCurrent, 12'h000, "zero cut");
		wr(`MPTL_SEL_FLAGS, 16'h0009);
		dateTime = 32'h0000_0004;
		loadPct = 12'h064;
		leakCmd = 12'h064;
		wait_trip(400, n);
		chk(n >= 190 && n <= 210, 1'b1, "ground delay");
		chk({auxTrip, tripOut, tripCause}, {2'h2, 4'h7}, "ground on aux");
		clr(1'b1);
		dateTime = 32'h0000_0005;
		loadPct = 12'h032;
		wait_trip(7000, n);
		chk(n > 2 * SEC - 5 && n <= 3 * SEC + 10, 1'b1, "under delay");
		chk(tripCause, 4'h6, "under cause");
		clr(1'b0);
		chk(histCount, 3'h5, "history count");
		for (int i = 0; i < 6; i++) begin
			histIdx = 3'(i);
			cyc(2);
			chk(histData, (i < 5) ? {expCause[i], 32'(5 - i)} : 36'h0_0000_0000, "history entry");
		end
		// Definite time at 200 percent, no operation delay, trips once the count passes one second
		wr(`MPTL_SEL_DTMODE, 16'h0001);
		wr(`MPTL_SEL_DDELAY, 16'h0000);
		wr(`MPTL_SEL_OTIME, 16'h0001);
		loadPct = 12'h0C8;
		wait_trip(5000, n);
		chk(n > SEC && n <= 2 * SEC + 10 && tripCause == 4'h1, 1'b1, "definite time");
		clr(1'b0);
		chk({maintAlarm, hoursRun}, 17'h0_0000, "hours below limit");
		lockReq = 1'b1;
		cyc(1);
		lockReq = 1'b0;
		wr(`MPTL_SEL_CLASS, 16'h0005);
		chk({unlocked, rejSeen}, 2'h1, "relocked write");
		finish_test();
	end
endmodule
`default_nettype wire
